// ---- verilog/mpb_pkg.sv ----
// Purpose: shared constants and types for the memory/peripheral bus port
// Assumes: 40 MHz clk_sys, byte-wide external data bus
// Notes: boot vector is captured from the address pins during cold reset
package mpb_pkg;
    localparam int ADDR_W = 22; // dedicated address outputs
    localparam int UPPER_W = 4; // upper address bits on alternate pins
    localparam int DATA_W = 8; // data bus width
    localparam int CS_W = 4; // chip select count
    localparam int BOOT_W = 16; // boot vector width
    localparam int BOOT_WDOG_BIT = 11; // watchdog disable position
    localparam int BOOT_RSV_LO = 12; // first reserved boot bit
    localparam int BOOT_RSV_HI = 15; // last reserved boot bit
    localparam int SYNC_W = 2; // warm reset synchroniser depth
    localparam logic [CS_W-1:0] CS_IDLE = 4'hf; // all selects negated
    localparam logic [BOOT_W-1:0] BOOT_RST = 16'h0000; // boot vector reset
    // bus states, gray along idle -> setup -> strobe -> hold
    typedef enum logic [1:0] {
        MPB_IDLE = 2'h0,
        MPB_SETUP = 2'h1,
        MPB_STROBE = 2'h3,
        MPB_HOLD = 2'h2
    } mpb_state_e;
endpackage : mpb_pkg

// ---- verilog/mpb_sync.sv ----
// Purpose: two-flop synchroniser for an asynchronous level
// Assumes: single clock domain on the output side
// Notes: reset value is a parameter so low-active lines reset idle
`timescale 1ns/10ps
module mpb_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input wire logic clk_sys,
    input wire logic warm_reset_n,
    input wire logic d_in,
    output logic d_out
);
    // first flop read only by the second
    typedef struct packed {
        logic meta;
        logic stab;
    } mpb_sync_s;
    mpb_sync_s st_q;
    mpb_sync_s st_d;

    // next state
    always_comb begin
        st_d = st_q;
        st_d.meta = d_in;
        st_d.stab = st_q.meta;
    end

    // registers
    always_ff @(posedge clk_sys or negedge warm_reset_n) begin
        if (!warm_reset_n) begin
            st_q <= {RST_VAL, RST_VAL};
        end else begin
            st_q <= st_d;
        end
    end

    assign d_out = st_q.stab;
endmodule : mpb_sync

// ---- verilog/mpb_bus.sv ----
// Purpose: external memory and peripheral bus port with boot capture
// Assumes: requests arrive on a simple req/ack user port
// Notes: wait_or_ack_n meaning chosen by ack_mode
// Operation
// - names ending _n are low active
// - drive transceiver direction output
// - low-active buffer enable output
// - low-active write strobe on writes
// - four low-active chip selects
// - 22-bit address plus four upper bits
// - bidirectional byte data bus
// - sample boot vector during cold reset
// - read strobe only when device drives
// - read_not_write high read, low write
// - wait mode stretches cycle while asserted
// - ack mode ends transaction on ack
// - boot bit eleven set disables watchdog
// - warm reset bidirectional and synchronised
`timescale 1ns/10ps
module mpb_bus (
    input wire logic clk_sys,
    input wire logic warm_reset_n,
    input wire logic power_on_reset_n,
    input wire logic warm_reset_n_in,
    output logic warm_reset_n_out,
    output logic warm_reset_n_oe,
    input wire logic ack_mode,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_read,
    input wire logic [1:0] req_cs,
    input wire logic [25:0] req_addr,
    input wire logic [7:0] req_wdata,
    output logic rsp_valid,
    output logic [7:0] rsp_rdata,
    output logic [21:0] bus_addr,
    output logic [3:0] bus_addr_upper,
    input wire logic [21:0] bus_addr_in,
    output logic bus_addr_oe,
    input wire logic [7:0] bus_data_in,
    output logic [7:0] bus_data_out,
    output logic bus_data_oe,
    output logic [3:0] dev_select_n,
    output logic read_not_write,
    output logic bus_read_strobe_n,
    output logic bus_write_strobe_n,
    output logic buf_dir_n,
    output logic buf_oe_n,
    input wire logic wait_or_ack_n,
    output logic [15:0] boot_vector,
    output logic watchdog_enable,
    output logic boot_reserved_err,
    output logic warm_reset_active
);
    // whole block state
    typedef struct packed {
        mpb_pkg::mpb_state_e st;
        logic rd;
        logic [mpb_pkg::CS_W-1:0] sel_n;
        logic [mpb_pkg::ADDR_W+mpb_pkg::UPPER_W-1:0] addr;
        logic [mpb_pkg::DATA_W-1:0] wdata;
        logic [mpb_pkg::DATA_W-1:0] rdata;
        logic done;
        logic [mpb_pkg::BOOT_W-1:0] boot;
        logic wdog_en;
        logic rsv_err;
        logic cold_q;
    } mpb_bus_s;
    mpb_bus_s s_q;
    mpb_bus_s s_d;
    logic warm_sync; // synchronised warm reset level
    logic in_reset; // any reset in force
    logic cycle_end; // external side lets the strobe end

    // asynchronous warm reset input brought into clk_sys
    mpb_sync #(.RST_VAL(1'b0)) u_warm_sync (
        .clk_sys(clk_sys),
        .warm_reset_n(warm_reset_n),
        .d_in(warm_reset_n_in),
        .d_out(warm_sync)
    );

    // cold reset input is taken as synchronous to clk_sys
    assign in_reset = !power_on_reset_n || !warm_sync;
    // wait mode: stretch while low; ack mode: finish when low
    assign cycle_end = ack_mode ? !wait_or_ack_n : wait_or_ack_n;

    // next-state logic
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        s_d.cold_q = !power_on_reset_n;
        if (!power_on_reset_n) begin
            // boot vector follows the pins for as long as cold reset holds
            s_d.boot = bus_addr_in[mpb_pkg::BOOT_W-1:0];
            s_d.st = mpb_pkg::MPB_IDLE;
            s_d.sel_n = mpb_pkg::CS_IDLE;
        end else if (s_q.cold_q) begin
            // release edge: latch the derived configuration
            s_d.wdog_en = !s_q.boot[mpb_pkg::BOOT_WDOG_BIT];
            // the reserved field must read back all low
            s_d.rsv_err = |s_q.boot[mpb_pkg::BOOT_RSV_HI:mpb_pkg::BOOT_RSV_LO];
        end else if (!warm_sync) begin
            // warm reset aborts any cycle and negates strobes
            s_d.st = mpb_pkg::MPB_IDLE;
            s_d.sel_n = mpb_pkg::CS_IDLE;
        end else begin
            unique case (s_q.st)
                mpb_pkg::MPB_IDLE: begin
                    if (req_valid) begin
                        s_d.st = mpb_pkg::MPB_SETUP;
                        s_d.rd = req_read;
                        s_d.addr = req_addr;
                        s_d.wdata = req_wdata;
                        // one-hot low select from the index
                        s_d.sel_n = ~(4'h1 << req_cs);
                    end
                end
                mpb_pkg::MPB_SETUP: begin
                    s_d.st = mpb_pkg::MPB_STROBE;
                end
                mpb_pkg::MPB_STROBE: begin
                    // stay in strobe until the far side lets go
                    if (cycle_end) begin
                        s_d.st = mpb_pkg::MPB_HOLD;
                        if (s_q.rd) begin
                            s_d.rdata = bus_data_in; // sample on read
                        end
                    end
                end
                mpb_pkg::MPB_HOLD: begin
                    s_d.st = mpb_pkg::MPB_IDLE;
                    s_d.sel_n = mpb_pkg::CS_IDLE;
                    s_d.done = 1'b1;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge clk_sys or negedge warm_reset_n) begin
        if (!warm_reset_n) begin
            s_q <= '{st: mpb_pkg::MPB_IDLE, rd: 1'b1, sel_n: mpb_pkg::CS_IDLE,
                     addr: '0, wdata: '0, rdata: '0, done: 1'b0,
                     boot: mpb_pkg::BOOT_RST, wdog_en: 1'b1, rsv_err: 1'b0,
                     cold_q: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    // outputs
    assign req_ready = (s_q.st == mpb_pkg::MPB_IDLE) && !in_reset && !s_q.cold_q;
    assign rsp_valid = s_q.done;
    assign rsp_rdata = s_q.rdata;
    assign bus_addr = s_q.addr[mpb_pkg::ADDR_W-1:0];
    assign bus_addr_upper = s_q.addr[mpb_pkg::ADDR_W+mpb_pkg::UPPER_W-1:mpb_pkg::ADDR_W];
    // address pins float while cold reset samples the boot vector
    assign bus_addr_oe = power_on_reset_n;
    assign bus_data_out = s_q.wdata;
    // drive data only for writes out of reset
    assign bus_data_oe = !in_reset && !s_q.rd && (s_q.st != mpb_pkg::MPB_IDLE);
    assign dev_select_n = in_reset ? mpb_pkg::CS_IDLE : s_q.sel_n;
    assign read_not_write = s_q.rd;
    // read strobe only while the device is to drive data
    assign bus_read_strobe_n = !(!in_reset && s_q.rd && s_q.st == mpb_pkg::MPB_STROBE);
    assign bus_write_strobe_n = !(!in_reset && !s_q.rd && s_q.st == mpb_pkg::MPB_STROBE);
    // transceiver passes toward pins on writes, low means inbound
    assign buf_dir_n = !s_q.rd;
    assign buf_oe_n = in_reset || (s_q.st == mpb_pkg::MPB_IDLE);
    // warm reset pin driven low during cold reset
    assign warm_reset_n_out = 1'b0;
    assign warm_reset_n_oe = !power_on_reset_n;
    assign boot_vector = s_q.boot;
    assign watchdog_enable = s_q.wdog_en;
    assign boot_reserved_err = s_q.rsv_err;
    assign warm_reset_active = !warm_sync;

    // strobes negated whenever any reset holds
    property p_idle_in_reset;
        @(posedge clk_sys) disable iff (!warm_reset_n)
        in_reset |-> (dev_select_n == mpb_pkg::CS_IDLE) && bus_read_strobe_n
            && bus_write_strobe_n && buf_oe_n;
    endproperty
    a_idle_in_reset: assert property (p_idle_in_reset) else $error("strobe in reset");

    // a read strobe never coincides with driven data
    property p_rd_no_drive;
        @(posedge clk_sys) disable iff (!warm_reset_n)
        !bus_read_strobe_n |-> !bus_data_oe && read_not_write;
    endproperty
    a_rd_no_drive: assert property (p_rd_no_drive) else $error("read strobe while driving");

    // write strobe only on write cycles
    property p_wr_dir;
        @(posedge clk_sys) disable iff (!warm_reset_n)
        !bus_write_strobe_n |-> !read_not_write && bus_data_oe;
    endproperty
    a_wr_dir: assert property (p_wr_dir) else $error("write strobe on read");

    // wait mode: held wait keeps the strobe
    property p_wait_hold;
        @(posedge clk_sys) disable iff (!warm_reset_n || in_reset)
        (s_q.st == mpb_pkg::MPB_STROBE && !ack_mode && !wait_or_ack_n)
            |=> (s_q.st == mpb_pkg::MPB_STROBE);
    endproperty
    a_wait_hold: assert property (p_wait_hold) else $error("wait ignored");

    // ack mode: ack ends strobe next cycle, done two later
    property p_ack_end;
        @(posedge clk_sys) disable iff (!warm_reset_n || in_reset)
        (s_q.st == mpb_pkg::MPB_STROBE && ack_mode && !wait_or_ack_n)
            |=> (s_q.st == mpb_pkg::MPB_HOLD) ##1 rsp_valid;
    endproperty
    a_ack_end: assert property (p_ack_end) else $error("ack did not end cycle");

    // boot vector equals pins one cycle after sampling in cold reset
    property p_boot_cap;
        @(posedge clk_sys) disable iff (!warm_reset_n)
        !power_on_reset_n |=> boot_vector == $past(bus_addr_in[15:0]);
    endproperty
    a_boot_cap: assert property (p_boot_cap) else $error("boot vector not captured");

    // watchdog follows the captured bit after release
    property p_wdog;
        @(posedge clk_sys) disable iff (!warm_reset_n)
        (s_q.cold_q && power_on_reset_n) |=>
            watchdog_enable == !$past(s_q.boot[mpb_pkg::BOOT_WDOG_BIT]);
    endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog enable wrong");

    // exactly one select low in an active cycle
    property p_one_sel;
        @(posedge clk_sys) disable iff (!warm_reset_n)
        (!in_reset && s_q.st != mpb_pkg::MPB_IDLE) |-> $onehot(~dev_select_n);
    endproperty
    a_one_sel: assert property (p_one_sel) else $error("select not one-hot");

    // with the buffer open, it points outward exactly when the port drives data on a write
    property p_dir;
        @(posedge clk_sys) disable iff (!warm_reset_n)
        !buf_oe_n |-> (buf_dir_n == bus_data_oe);
    endproperty
    a_dir: assert property (p_dir) else $error("buffer direction wrong");
endmodule : mpb_bus

// ---- testbench/mpb_mem_model.sv ----
// Purpose: external byte memory that answers the bus port
// Assumes: one 16-byte store behind all four selects
// Notes: dly_cfg sets how many strobe cycles the memory stalls
`timescale 1ns/10ps
module mpb_mem_model (
    input wire logic clk_sys,
    input wire logic ack_mode,
    input wire logic [3:0] dly_cfg,
    input wire logic [3:0] dev_select_n,
    input wire logic [21:0] bus_addr,
    input wire logic [7:0] bus_data_out,
    input wire logic read_not_write,
    input wire logic bus_read_strobe_n,
    input wire logic bus_write_strobe_n,
    output logic [7:0] bus_data_in,
    output logic wait_or_ack_n
);
    logic [7:0] mem [16]; // byte store
    logic [3:0] cnt; // strobe cycles seen so far
    logic [7:0] last = 8'h5a; // last byte put on the bus
    logic sel; // any select low
    logic strb; // selected and strobed
    assign sel = (dev_select_n != 4'hf);
    assign strb = sel && !(bus_read_strobe_n && bus_write_strobe_n);
    // stall counter, write capture, memory of the last driven byte
    always @(posedge clk_sys) begin
        cnt <= strb ? cnt + 4'h1 : 4'h0;
        if (strb && !bus_write_strobe_n) begin
            mem[bus_addr[3:0]] <= bus_data_out;
        end
        if (sel && read_not_write) begin
            last <= mem[bus_addr[3:0]];
        end
    end
    // released bus shows the inverse, so a stale sample cannot pass
    assign bus_data_in = (sel && read_not_write) ? mem[bus_addr[3:0]] : ~last;
    // pulled-up line: ack goes low once stalled, wait stays low while stalling
    assign wait_or_ack_n = ack_mode ? !(strb && cnt >= dly_cfg) : !(strb && cnt < dly_cfg);
endmodule : mpb_mem_model

// ---- testbench/mpb_bus_bench.sv ----
// Purpose: self-checking bench for the bus port and boot capture
// Assumes: 40 MHz clock, inputs change 1 ns after the rising edge
// Notes: strobe length is expected to be the model stall plus one
`timescale 1ns/10ps
module mpb_bus_bench;
    logic clk_sys = 1'b0; // system clock
    logic warm_reset_n = 1'b0; // async reset
    logic power_on_reset_n = 1'b0; // cold reset
    logic warm_drv = 1'b1; // far side drive on the warm reset pin
    logic ack_mode = 1'b0; // wait line meaning
    logic req_valid = 1'b0, req_read = 1'b0;
    logic [1:0] req_cs = 2'h0;
    logic [25:0] req_addr = 26'h0;
    logic [7:0] req_wdata = 8'h00;
    logic [21:0] bus_addr_in = 22'h0; // boot straps
    logic [3:0] dly_cfg = 4'h0; // memory stall
    logic warm_reset_n_out, warm_reset_n_oe, req_ready, rsp_valid, bus_addr_oe, bus_data_oe;
    logic read_not_write, bus_read_strobe_n, bus_write_strobe_n, buf_dir_n, buf_oe_n;
    logic wait_or_ack_n, watchdog_enable, boot_reserved_err, warm_reset_active;
    // shared warm reset pin: the device's low drive wins, else the far side
    wire warm_pin = warm_reset_n_oe ? warm_reset_n_out : warm_drv;
    logic [7:0] rsp_rdata, bus_data_in, bus_data_out;
    logic [21:0] bus_addr;
    logic [3:0] bus_addr_upper, dev_select_n;
    logic [15:0] boot_vector;
    logic [15:0] boot_tab [4] = '{16'h0800, 16'h0000, 16'h3000, 16'hc800}; // straps to try
    int fail_count = 0; // mismatches
    int check_count = 0; // comparisons
    mpb_bus i_dut (.clk_sys, .warm_reset_n, .power_on_reset_n, .warm_reset_n_in(warm_pin),
        .warm_reset_n_out,
        .warm_reset_n_oe, .ack_mode, .req_valid, .req_ready, .req_read, .req_cs, .req_addr,
        .req_wdata, .rsp_valid, .rsp_rdata, .bus_addr, .bus_addr_upper, .bus_addr_in,
        .bus_addr_oe, .bus_data_in, .bus_data_out, .bus_data_oe, .dev_select_n,
        .read_not_write, .bus_read_strobe_n, .bus_write_strobe_n, .buf_dir_n, .buf_oe_n,
        .wait_or_ack_n, .boot_vector, .watchdog_enable, .boot_reserved_err, .warm_reset_active);
    mpb_mem_model i_mem (.clk_sys, .ack_mode, .dly_cfg, .dev_select_n, .bus_addr,
        .bus_data_out, .read_not_write, .bus_read_strobe_n, .bus_write_strobe_n,
        .bus_data_in, .wait_or_ack_n);
    // free-running clock
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    // one comparison, counted
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // step to just after the n-th rising edge from now
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick
    // cold reset with given straps; reserved bits are nonzero only on purpose
    task automatic boot(input logic [15:0] v);
        power_on_reset_n = 1'b0;
        bus_addr_in = {6'h15, v};
        tick(3);
        chk(warm_reset_n_oe, 1);
        chk(warm_reset_n_out, 0);
        chk(warm_reset_active, 1);
        chk(bus_addr_oe, 0);
        chk(dev_select_n, 4'hf);
        chk(boot_vector, v);
        power_on_reset_n = 1'b1;
        bus_addr_in = ~bus_addr_in; // pins no longer carry the straps
        tick(2);
        chk(watchdog_enable, !v[11]);
        chk(boot_reserved_err, v[15:12] != 4'h0);
        chk(boot_vector, v);
        chk(bus_addr_oe, 1);
    endtask : boot
    // one request on the user port, pins watched every cycle until the answer
    task automatic bus_op(input logic rd, input logic [1:0] cs, input logic [25:0] a,
                          input logic [7:0] d);
        int n;
        int strb;
        n = 0;
        strb = 0;
        while (req_ready !== 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
        chk(req_ready, 1);
        req_valid = 1'b1;
        req_read = rd;
        req_cs = cs;
        req_addr = a;
        req_wdata = d;
        tick(1);
        req_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 40) begin
            if (dev_select_n !== 4'hf) begin
                chk(dev_select_n, 4'(~(4'h1 << cs)));
                chk(read_not_write, rd);
                chk(buf_dir_n, !rd);
                chk({bus_addr_upper, bus_addr}, a);
                chk(buf_oe_n, 0);
                chk(bus_data_oe, !rd);
            end
            if (!bus_read_strobe_n || !bus_write_strobe_n) begin
                strb++;
                chk(rd ? bus_write_strobe_n : bus_read_strobe_n, 1);
                chk(rd ? bus_data_in : bus_data_out, d);
            end
            tick(1);
            n++;
        end
        chk(n < 40, 1);
        chk(strb, dly_cfg + 1);
        chk(rd ? rsp_rdata : i_mem.mem[a[3:0]], d);
        tick(1);
        chk({dev_select_n, buf_oe_n, bus_read_strobe_n, bus_write_strobe_n}, 7'h7f);
    endtask : bus_op
    // verdict and end of run
    task automatic give_verdict;
        $display("checks=%0d mismatches=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict
    // hang guard, well beyond the fewer than one hundred cycles the tests take
    initial begin
        repeat (3000) @(posedge clk_sys);
        fail_count++;
        give_verdict();
    end
    // main sequence
    initial begin
        tick(4);
        chk({dev_select_n, buf_oe_n, bus_write_strobe_n}, 6'h3f);
        warm_reset_n = 1'b1;
        for (int b = 0; b < 4; b++) begin
            boot(boot_tab[b]);
        end
        warm_drv = 1'b0;
        tick(4);
        chk(warm_reset_active, 1);
        warm_drv = 1'b1;
        tick(4);
        chk(warm_reset_active, 0);
        for (int k = 0; k < 4; k++) begin
            ack_mode = k[1];
            dly_cfg = k[0] ? 4'h3 : 4'h0;
            bus_op(1'b0, k[1:0], {k[3:0], 18'h2a5c3, k[3:0]}, 8'hc3 ^ 8'(k));
            bus_op(1'b1, k[1:0], {k[3:0], 18'h2a5c3, k[3:0]}, 8'hc3 ^ 8'(k));
        end
        give_verdict();
    end
endmodule : mpb_bus_bench
